// *** common/ifml_map.vh ***
// Register map and field constants of the input fault mask and latch block
`ifndef IFML_MAP_VH
`define IFML_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IFML_ADDR_FAULT_MASK_THREE 8'h34
`define IFML_ADDR_POS_OV_LATCH 8'h35
`define IFML_ADDR_NEG_OV_LATCH 8'h36
`define IFML_ADDR_CHAN1_FAULT_LATCH 8'h2E
`define IFML_ADDR_CHAN2_FAULT_LATCH 8'h2F
`define IFML_ADDR_CHAN3_FAULT_LATCH 8'h30
`define IFML_ADDR_CHAN4_FAULT_LATCH 8'h31

// ----------------------------------------
// Field positions of the mask register
// ----------------------------------------
`define IFML_MASK_POS_OV_BIT 7
`define IFML_MASK_NEG_OV_BIT 6
`define IFML_MASK_BIAS_HIGH_BIT 5
`define IFML_MASK_BIAS_LOW_BIT 4
`define IFML_MASK_BIAS_OV_BIT 3
`define IFML_MASK_FIELD_LSB 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IFML_MASK_RESET 5'h00
`define IFML_LATCH_RESET 4'h0
`define IFML_RDATA_RESET 8'h00
`define IFML_MASK_RSVD_VALUE 3'h0
`define IFML_LATCH_RSVD_VALUE 4'h0

`endif

// *** hdl/ifml_top.v ***
// Fault mask register and latched over-voltage status registers with interrupt request
`include "ifml_map.vh"

module ifml_top #(
  parameter NUM_CHAN = 4
) (
  clk,
  rst_n,
  regAddr,
  regWrEn,
  regWrData,
  regRdEn,
  regRdData,
  posOverVolt,
  negOverVolt,
  biasHighCurLatched,
  biasLowCurLatched,
  biasOverVoltLatched,
  chanLatchRdPulse,
  chanBit0ClrPulse,
  faultIrq
);
  input wire clk;
  input wire rst_n;
  input wire [7:0] regAddr;
  input wire regWrEn;
  input wire [7:0] regWrData;
  input wire regRdEn;
  output wire [7:0] regRdData;
  input wire [NUM_CHAN-1:0] posOverVolt;
  input wire [NUM_CHAN-1:0] negOverVolt;
  input wire biasHighCurLatched;
  input wire biasLowCurLatched;
  input wire biasOverVoltLatched;
  output wire [NUM_CHAN-1:0] chanLatchRdPulse;
  output wire chanBit0ClrPulse;
  output wire faultIrq;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Every hit is qualified by its strobe, so an idle address never acts
  function rdHit;
    input rdEn;
    input [7:0] addr;
    input [7:0] target;
    begin
      rdHit = rdEn && (addr == target);
    end
  endfunction

  function wrHit;
    input wrEn;
    input [7:0] addr;
    input [7:0] target;
    begin
      wrHit = wrEn && (addr == target);
    end
  endfunction

  // Mask fields are stored without the reserved low bits
  function maskBit;
    input [4:0] mask;
    input integer bitPos;
    begin
      maskBit = mask[bitPos - `IFML_MASK_FIELD_LSB];
    end
  endfunction

  // ----------------------------------------
  // Address hits
  // ----------------------------------------
  // Read and write may share a cycle; they act independently
  wire hitMaskWr;
  wire hitMaskRd;
  wire hitPosRd;
  wire hitNegRd;
  wire hitChan1Rd;
  wire hitChan2Rd;
  wire hitChan3Rd;
  wire hitChan4Rd;

  assign hitMaskWr = wrHit(regWrEn, regAddr, `IFML_ADDR_FAULT_MASK_THREE);
  assign hitMaskRd = rdHit(regRdEn, regAddr, `IFML_ADDR_FAULT_MASK_THREE);
  assign hitPosRd = rdHit(regRdEn, regAddr, `IFML_ADDR_POS_OV_LATCH);
  assign hitNegRd = rdHit(regRdEn, regAddr, `IFML_ADDR_NEG_OV_LATCH);
  assign hitChan1Rd = rdHit(regRdEn, regAddr, `IFML_ADDR_CHAN1_FAULT_LATCH);
  assign hitChan2Rd = rdHit(regRdEn, regAddr, `IFML_ADDR_CHAN2_FAULT_LATCH);
  assign hitChan3Rd = rdHit(regRdEn, regAddr, `IFML_ADDR_CHAN3_FAULT_LATCH);
  assign hitChan4Rd = rdHit(regRdEn, regAddr, `IFML_ADDR_CHAN4_FAULT_LATCH);

  // ----------------------------------------
  // Detector synchronisers
  // ----------------------------------------
  // Comparators are analog and asynchronous to clk
  // Both stages reset so no false fault follows reset
  reg [NUM_CHAN-1:0] posMeta_q;
  reg [NUM_CHAN-1:0] posSync_q;
  reg [NUM_CHAN-1:0] negMeta_q;
  reg [NUM_CHAN-1:0] negSync_q;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      posMeta_q <= {NUM_CHAN{1'b0}};
      posSync_q <= {NUM_CHAN{1'b0}};
    end
    else
    begin
      posMeta_q <= posOverVolt;
      posSync_q <= posMeta_q;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      negMeta_q <= {NUM_CHAN{1'b0}};
      negSync_q <= {NUM_CHAN{1'b0}};
    end
    else
    begin
      negMeta_q <= negOverVolt;
      negSync_q <= negMeta_q;
    end
  end

  // ----------------------------------------
  // Clear pulses
  // ----------------------------------------
  // Index 3 is channel 1 so the latch maps straight onto bits 7..4
  reg [NUM_CHAN-1:0] chanRd;
  always @*
  begin
    chanRd = {NUM_CHAN{1'b0}};
    if (hitChan1Rd)
      chanRd[3] = 1'b1;
    else if (hitChan2Rd)
      chanRd[2] = 1'b1;
    else if (hitChan3Rd)
      chanRd[1] = 1'b1;
    else if (hitChan4Rd)
      chanRd[0] = 1'b1;
  end

  assign chanLatchRdPulse = chanRd;
  // Channel registers live outside; they only need to see the readback of the negative latch
  assign chanBit0ClrPulse = hitNegRd;

  // ----------------------------------------
  // Write fields
  // ----------------------------------------
  // Bits 2..0 of the write data are reserved and deliberately dropped
  wire wrPosOvMask;
  wire wrNegOvMask;
  wire wrBiasHighMask;
  wire wrBiasLowMask;
  wire wrBiasOvMask;

  assign wrPosOvMask = regWrData[`IFML_MASK_POS_OV_BIT];
  assign wrNegOvMask = regWrData[`IFML_MASK_NEG_OV_BIT];
  assign wrBiasHighMask = regWrData[`IFML_MASK_BIAS_HIGH_BIT];
  assign wrBiasLowMask = regWrData[`IFML_MASK_BIAS_LOW_BIT];
  assign wrBiasOvMask = regWrData[`IFML_MASK_BIAS_OV_BIT];

  // ----------------------------------------
  // Mask register
  // ----------------------------------------
  reg [4:0] mask_q;
  wire [4:0] mask_d;
  // Reserved low bits are never stored, so a stray write cannot reach them
  assign mask_d[4] = hitMaskWr ? wrPosOvMask : mask_q[4];
  assign mask_d[3] = hitMaskWr ? wrNegOvMask : mask_q[3];
  assign mask_d[2] = hitMaskWr ? wrBiasHighMask : mask_q[2];
  assign mask_d[1] = hitMaskWr ? wrBiasLowMask : mask_q[1];
  assign mask_d[0] = hitMaskWr ? wrBiasOvMask : mask_q[0];

  always @(posedge clk)
  begin
    if (!rst_n)
      mask_q <= `IFML_MASK_RESET;
    else
      mask_q <= mask_d;
  end

  // ----------------------------------------
  // Over-voltage latches
  // ----------------------------------------
  // Set wins over clear so a fault arriving during the clearing read is kept
  // Clears come only from the channel reads, never from reading the latches themselves
  reg [NUM_CHAN-1:0] posLatch_q;
  reg [NUM_CHAN-1:0] negLatch_q;
  wire [NUM_CHAN-1:0] posLatch_d;
  wire [NUM_CHAN-1:0] negLatch_d;

  assign posLatch_d[3] = posSync_q[3] | (posLatch_q[3] & ~chanRd[3]);
  assign posLatch_d[2] = posSync_q[2] | (posLatch_q[2] & ~chanRd[2]);
  assign posLatch_d[1] = posSync_q[1] | (posLatch_q[1] & ~chanRd[1]);
  assign posLatch_d[0] = posSync_q[0] | (posLatch_q[0] & ~chanRd[0]);
  assign negLatch_d[3] = negSync_q[3] | (negLatch_q[3] & ~chanRd[3]);
  assign negLatch_d[2] = negSync_q[2] | (negLatch_q[2] & ~chanRd[2]);
  assign negLatch_d[1] = negSync_q[1] | (negLatch_q[1] & ~chanRd[1]);
  assign negLatch_d[0] = negSync_q[0] | (negLatch_q[0] & ~chanRd[0]);

  always @(posedge clk)
  begin
    if (!rst_n)
      posLatch_q <= `IFML_LATCH_RESET;
    else
      posLatch_q <= posLatch_d;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
      negLatch_q <= `IFML_LATCH_RESET;
    else
      negLatch_q <= negLatch_d;
  end

  // ----------------------------------------
  // Class status
  // ----------------------------------------
  // One request per class; the host finds the channel by reading back
  wire posAny;
  wire negAny;
  assign posAny = |posLatch_q;
  assign negAny = |negLatch_q;

  // ----------------------------------------
  // Readback words
  // ----------------------------------------
  wire [7:0] maskWord;
  wire [7:0] posWord;
  wire [7:0] negWord;

  assign maskWord = {mask_q, `IFML_MASK_RSVD_VALUE};
  assign posWord = {posLatch_q, `IFML_LATCH_RSVD_VALUE};
  assign negWord = {negLatch_q, `IFML_LATCH_RSVD_VALUE};

  // ----------------------------------------
  // Readback select
  // ----------------------------------------
  // Binary select codes for the readback multiplexer
  localparam SEL_NONE = 2'h0;
  localparam SEL_MASK = 2'h1;
  localparam SEL_POS = 2'h2;
  localparam SEL_NEG = 2'h3;
  reg [1:0] rdSel;
  always @*
  begin
    rdSel = SEL_NONE;
    if (hitMaskRd)
      rdSel = SEL_MASK;
    else if (hitPosRd)
      rdSel = SEL_POS;
    else if (hitNegRd)
      rdSel = SEL_NEG;
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Holding the last word lets a slow host fetch it any time before the next read
  reg [7:0] rdData_q;
  reg [7:0] rdData_d;
  always @*
  begin
    rdData_d = rdData_q;
    if (regRdEn)
    begin
      if (rdSel == SEL_MASK)
        rdData_d = maskWord;
      else if (rdSel == SEL_POS)
        rdData_d = posWord;
      else if (rdSel == SEL_NEG)
        rdData_d = negWord;
      else
        rdData_d = `IFML_RDATA_RESET;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
      rdData_q <= `IFML_RDATA_RESET;
    else
      rdData_q <= rdData_d;
  end

  assign regRdData = rdData_q;

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  // Bias levels already come latched on clk, so they feed the request directly
  wire posOvReq;
  wire negOvReq;
  wire biasHighReq;
  wire biasLowReq;
  wire biasOvReq;
  wire irq_d;
  reg irq_q;

  assign posOvReq = posAny & ~maskBit(mask_q, `IFML_MASK_POS_OV_BIT);
  assign negOvReq = negAny & ~maskBit(mask_q, `IFML_MASK_NEG_OV_BIT);
  assign biasHighReq = biasHighCurLatched & ~maskBit(mask_q, `IFML_MASK_BIAS_HIGH_BIT);
  assign biasLowReq = biasLowCurLatched & ~maskBit(mask_q, `IFML_MASK_BIAS_LOW_BIT);
  assign biasOvReq = biasOverVoltLatched & ~maskBit(mask_q, `IFML_MASK_BIAS_OV_BIT);
  assign irq_d = posOvReq | negOvReq | biasHighReq | biasLowReq | biasOvReq;

  // Registered so a glitch on the combined request cannot reach the pin
  always @(posedge clk)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  assign faultIrq = irq_q;

endmodule // ifml_top

// *** dv/ifml_properties.sv ***
// Port checker for the fault mask and latch block
module ifml_properties #(
  parameter NUM_CHAN = 4
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] regAddr,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regRdData,
  input wire [NUM_CHAN-1:0] posOverVolt,
  input wire [NUM_CHAN-1:0] chanLatchRdPulse,
  input wire chanBit0ClrPulse,
  input wire faultIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  wire rd34 = regRdEn && regAddr == 8'h34;
  wire rdOv = regRdEn && (regAddr == 8'h35 || regAddr == 8'h36);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // No write beside the read, so the read value is the live mask
  sequence s_m34; rd34 && !regWrEn ##1 !regWrEn; endsequence
  property p_m0; rd34 |=> regRdData[2:0] == 3'h0; endproperty
  property p_lo; rdOv |=> regRdData[3:0] == 4'h0; endproperty
  property p_unm; regRdEn && !rd34 && !rdOv |=> regRdData == 8'h00; endproperty
  property p_hold; !regRdEn |=> $stable(regRdData); endproperty
  property p_chp; chanLatchRdPulse == ({4{regRdEn}} & {regAddr == 8'h2E, regAddr == 8'h2F,
    regAddr == 8'h30, regAddr == 8'h31}); endproperty
  property p_clr; chanBit0ClrPulse == (regRdEn && regAddr == 8'h36); endproperty
  property p_mask; s_m34 ##0 regRdData == 8'hF8 |=> !faultIrq; endproperty
  // Six cycles span the synchroniser, the latch and the request flop
  property p_ov; s_m34 ##0 !regRdData[7] ##1 !regWrEn ##1 (posOverVolt[3] && !regWrEn) [*6] |-> faultIrq;
  endproperty
  a_m0: assert property (p_m0) else $error("mask low bits set");
  a_lo: assert property (p_lo) else $error("latch low bits set");
  a_unm: assert property (p_unm) else $error("unmapped read");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_chp: assert property (p_chp) else $error("channel pulse wrong");
  a_clr: assert property (p_clr) else $error("bit0 clear wrong");
  a_mask: assert property (p_mask) else $error("masked irq");
  a_ov: assert property (p_ov) else $error("no irq");
endmodule // ifml_properties
bind ifml_top ifml_properties #(.NUM_CHAN(NUM_CHAN)) i_ifml_properties (.clk, .rst_n, .regAddr, .regWrEn,
  .regRdEn, .regRdData, .posOverVolt, .chanLatchRdPulse, .chanBit0ClrPulse, .faultIrq);

// *** dv/ifml_host.sv ***
// Host model driving the register port
module ifml_host (
  input wire clk,
  input wire [7:0] regRdData,
  output logic [7:0] regAddr = 8'h00,
  output logic [7:0] regWrData = 8'h00,
  output logic regWrEn = 1'b0,
  output logic regRdEn = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task wr(input [7:0] a, input [7:0] v);
    @(posedge clk);
    {regWrEn, regAddr, regWrData} <= {1'b1, a, v & (a == 8'h34 ? 8'hF8 : 8'hF0)};
    @(posedge clk);
    {regWrEn, regAddr, regWrData} <= {1'b0, ~a, ~v};
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge clk);
    {regRdEn, regAddr} <= {1'b1, a};
    @(posedge clk);
    {regRdEn, regAddr} <= {1'b0, ~a};
    @(posedge clk);
    d = regRdData;
  endtask
endmodule // ifml_host

// *** dv/input_fault_mask_and_latch_tb.sv ***
// Self-checking bench for the fault mask and latch block
module input_fault_mask_and_latch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, biasHighCurLatched = 0, biasLowCurLatched = 0, biasOverVoltLatched = 0;
  logic [3:0] posOverVolt = 0, negOverVolt = 0;
  logic [7:0] d, v;
  wire [7:0] regAddr, regWrData, regRdData;
  wire regWrEn, regRdEn, faultIrq;
  int errTotal, checked;
  ifml_host i_ifml_host (.clk, .regRdData, .regAddr, .regWrData, .regWrEn, .regRdEn);
  ifml_top i_ifml_top (.clk, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .posOverVolt,
    .negOverVolt, .biasHighCurLatched, .biasLowCurLatched, .biasOverVoltLatched, .chanLatchRdPulse(),
    .chanBit0ClrPulse(), .faultIrq);
  initial
    forever #10 clk = ~clk;
  function automatic logic [7:0] expClr(int i); return 8'hF0 >> (i + 1) & 8'hF0; endfunction
  task chk(input [7:0] got, input [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      errTotal++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task printVerdict;
    $display("checks %0d errors %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #200us;
    errTotal++;
    printVerdict;
  end
  initial
  begin
    v = $urandom(50390);
    repeat (8) @(posedge clk);
    rst_n <= 1;
    for (int a = 52; a < 56; a++)
    begin
      i_ifml_host.rd(8'(a), d);
      chk(d, 8'h00);
    end
    repeat (4)
    begin
      v = $urandom;
      i_ifml_host.wr(8'h34, v);
      i_ifml_host.rd(8'h34, d);
      chk(d, v & 8'hF8);
    end
    i_ifml_host.wr(8'h35, 8'hF0);
    i_ifml_host.rd(8'h35, d);
    chk(d, 8'h00);
    i_ifml_host.wr(8'h34, 8'h00);
    i_ifml_host.rd(8'h34, d);
    @(posedge clk);
    {posOverVolt, negOverVolt} <= 8'hFF;
    repeat (6) @(posedge clk);
    i_ifml_host.rd(8'h36, d);
    chk(d, 8'hF0);
    chk({7'h0, faultIrq}, 8'h01);
    i_ifml_host.wr(8'h34, 8'hC0);
    i_ifml_host.rd(8'h34, d);
    chk({7'h0, faultIrq}, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      i_ifml_host.wr(8'h34, 8'(8'h80 >> m));
      i_ifml_host.rd(8'h34, d);
      chk({7'h0, faultIrq}, 8'h01);
    end
    @(posedge clk);
    {posOverVolt, negOverVolt} <= 8'h00;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      i_ifml_host.rd(8'h2E + 8'(i), d);
      i_ifml_host.rd(8'h35, d);
      chk(d, expClr(i));
      i_ifml_host.rd(8'h36, d);
      chk(d, expClr(i));
    end
    for (int b = 0; b < 3; b++)
    begin
      @(posedge clk);
      {biasHighCurLatched, biasLowCurLatched, biasOverVoltLatched} <= 3'b100 >> b;
      i_ifml_host.wr(8'h34, 8'hF8);
      i_ifml_host.rd(8'h34, d);
      chk({7'h0, faultIrq}, 8'h00);
      i_ifml_host.wr(8'h34, 8'hF8 ^ (8'h20 >> b));
      i_ifml_host.rd(8'h34, d);
      chk({7'h0, faultIrq}, 8'h01);
    end
    printVerdict;
  end
endmodule // input_fault_mask_and_latch_tb
